// *** inc/ppwm_pkg.sv ***
// Package: constants, register map and carrier types of the program page window mapper
package ppwm_pkg;

  // ==========================================================================
  // Register map (index; byte address on the bus is four times the index)
  // ==========================================================================
  localparam logic [7:0] PPWM_IDX_BASE_POS = 8'h11; // Register block base position
  localparam logic [7:0] PPWM_IDX_PAGE_SEL = 8'h12; // Program page select
  localparam logic [7:0] PPWM_IDX_STATUS = 8'h13; // Sequencer status, read only
  localparam logic [7:0] PPWM_BASE_POS_RST = 8'h00; // Base position after reset
  localparam logic [5:0] PPWM_PAGE_RST = 6'h00; // Page select after reset

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int PPWM_BASE_LSB = 3; // Programmable base bits 6..3
  localparam int PPWM_BASE_MSB = 6;
  localparam logic [7:0] PPWM_BASE_MASK = 8'h78; // Bit 7 and bits 2..0 read zero
  localparam int PPWM_PAGE_W = 6; // 64 pages
  localparam int PPWM_PHYS_W = 22; // 64 pages of 16K in the low 20 bits, top two bits zero
  localparam logic [1:0] PPWM_WIN_TOP = 2'b10; // Expansion window at 0x8000..0xBFFF
  localparam logic [1:0] PPWM_UNPAGED_TOP = 2'b11; // 0xC000..0xFFFF never paged
  localparam logic [15:0] PPWM_PUSH_RET_OFS = 16'h0002; // Return word below stack
  localparam logic [15:0] PPWM_FRAME_BYTES = 16'h0003; // Word plus page byte
  localparam logic [15:0] PPWM_IND_PAGE_OFS = 16'h0002; // Page byte after target

  // ==========================================================================
  // Sequencer states, Gray coded along the call path
  // ==========================================================================
  typedef enum logic [3:0] {
    PPWM_IDLE = 4'b0000,
    PPWM_IND_ADDR = 4'b0001,
    PPWM_IND_PAGE = 4'b0011,
    PPWM_SWAP = 4'b0010,
    PPWM_PUSH_RET = 4'b0110,
    PPWM_PUSH_PAGE = 4'b0111,
    PPWM_REFILL = 4'b0101,
    PPWM_POP_PAGE = 4'b0100,
    PPWM_POP_RET = 4'b1100
  } ppwm_st_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic indirect; // Target and page come through a pointer
    logic [5:0] new_page; // Immediate page operand
    logic [15:0] target; // Target address, or pointer when indirect
    logic [15:0] ret_addr; // Address of instruction after the call
    logic [15:0] sp; // Stack pointer at start
  } ppwm_cmd_t;

  typedef struct packed {
    logic we; // Write
    logic wide; // 16-bit access, else byte
    logic [15:0] addr;
    logic [15:0] wdata;
  } ppwm_mem_t;

  typedef struct packed {
    logic [15:0] addr; // Fetch restart address
    logic [15:0] sp; // Stack pointer after the sequence
  } ppwm_fetch_t;

  typedef struct packed {
    logic reg_hit; // Address lies in the internal register block
    logic win_hit; // Address lies in the expansion window
    logic [21:0] phys; // Physical address
  } ppwm_dec_t;

  typedef struct packed {
    ppwm_st_t st;
    logic [7:0] base;
    logic locked;
    logic [5:0] page;
    logic [5:0] temp;
    logic [5:0] newpg;
    logic [15:0] ptr;
    logic [15:0] tgt;
    logic [15:0] ret;
    logic [15:0] sp;
    ppwm_mem_t mem;
    logic done;
    ppwm_fetch_t fetch;
    logic av_ack;
    logic [31:0] rdata;
    ppwm_dec_t dec;
  } ppwm_state_t;

endpackage

// *** rtl/ppwm_decode.sv ***
// Module: address decoder for register block placement and the page window
`timescale 1ns/1ps
module ppwm_decode (
  input wire logic [15:0] addr_i,
  input wire logic [5:0] page_i,
  input wire logic [7:0] base_i,
  input wire logic size_2k_i,
  output ppwm_pkg::ppwm_dec_t dec_o
);
  import ppwm_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Upper five base bits are a leading zero plus four programmable bits
  logic [4:0] blk_top; // Base address bits 15..11
  assign blk_top = {1'b0, base_i[PPWM_BASE_MSB:PPWM_BASE_LSB]}; // [RULE3]

  // Comb decode; a 1K block only claims the lower half of its 2K slot
  always_comb begin
    dec_o.reg_hit = (addr_i[15:11] == blk_top) && (size_2k_i || !addr_i[10]); // [RULE2]
    dec_o.win_hit = (addr_i[15:14] == PPWM_WIN_TOP);
    if (dec_o.win_hit) begin
      dec_o.phys = {2'b00, page_i, addr_i[13:0]}; // [RULE5]
    end else begin
      // Top 16K and the rest stay unpaged whatever the page value
      dec_o.phys = {6'h00, addr_i}; // [RULE6]
    end
  end
endmodule

// *** rtl/ppwm_top.sv ***
// Module: program page window mapper top with register slave and call/return sequencer
//
// Behaviour
// RULE1: base position written once unless special mode
// RULE2: register block relocatable, 2K aligned, low 32K
// RULE3: base top bits: zero plus four programmable
// RULE4: page select written by bus and sequencer
// RULE5: page selects one of 64 window pages
// RULE6: 0xC000 to 0xFFFF always unpaged
// RULE7: software keeps service entries in unpaged memory
// RULE8: call saves old page, loads new page
// RULE9: call pushes 16-bit return address
// RULE10: call then pushes saved page
// RULE11: call ends refilling at target in page
// RULE12: call and return are uninterruptible
// RULE13: page immediate, or via pointer when indirect
// RULE14: call allowed from anywhere to anywhere
// RULE15: return pops page, address, refills queue
// RULE16: return pops page first, then address
`timescale 1ns/1ps
module ppwm_top (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Mode and block size from the mode logic, same clock
  input wire logic MODE_SPECIAL_I,
  input wire logic REG_BLOCK_2K_I,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // CPU address to decode
  input wire logic [15:0] CPU_ADDR_I,
  output ppwm_pkg::ppwm_dec_t DEC_O,
  // Call and return requests from the core
  input wire logic CALL_REQ_I,
  input wire logic RTC_REQ_I,
  input wire ppwm_pkg::ppwm_cmd_t CMD_I,
  output logic CMD_READY_O,
  output logic BUSY_O,
  // Stack and operand memory port
  output logic MEM_REQ_O,
  output ppwm_pkg::ppwm_mem_t MEM_O,
  input wire logic MEM_ACK_I,
  input wire logic [15:0] MEM_RDATA_I,
  // Queue refill
  output logic DONE_O,
  output ppwm_pkg::ppwm_fetch_t FETCH_O,
  output logic [5:0] PAGE_O
);
  import ppwm_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  ppwm_state_t s_q; // All registered state
  ppwm_state_t s_d; // Next state
  ppwm_dec_t dec_c; // Combinational decode of the CPU address
  logic av_req; // Bus request present
  logic [7:0] av_idx; // Register index from byte address
  logic av_aligned; // Byte address is word aligned
  logic page_busy; // Page write must wait for the sequencer

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Memory access that each sequencer state performs
  function automatic ppwm_mem_t mem_for(input ppwm_st_t st, input logic [15:0] ptr,
                                        input logic [15:0] ret, input logic [15:0] sp,
                                        input logic [5:0] temp);
    ppwm_mem_t m;
    m = '0;
    case (st)
      PPWM_IND_ADDR: begin
        m.wide = 1'b1;
        m.addr = ptr; // Target word at the pointer
      end
      PPWM_IND_PAGE: begin
        m.addr = ptr + PPWM_IND_PAGE_OFS; // Page byte after target
      end
      PPWM_PUSH_RET: begin
        m.we = 1'b1;
        m.wide = 1'b1;
        m.addr = sp - PPWM_PUSH_RET_OFS;
        m.wdata = ret;
      end
      PPWM_PUSH_PAGE: begin
        m.we = 1'b1;
        m.addr = sp - PPWM_FRAME_BYTES;
        m.wdata = {10'h000, temp};
      end
      PPWM_POP_PAGE: begin
        m.addr = sp; // Page byte on top
      end
      PPWM_POP_RET: begin
        m.wide = 1'b1;
        m.addr = sp + 16'h0001;
      end
      default: begin
        m = '0;
      end
    endcase
    return m;
  endfunction

  // States that hold a memory request open
  function automatic logic is_mem_state(input ppwm_st_t st);
    return (st == PPWM_IND_ADDR) || (st == PPWM_IND_PAGE) || (st == PPWM_PUSH_RET) ||
           (st == PPWM_PUSH_PAGE) || (st == PPWM_POP_PAGE) || (st == PPWM_POP_RET);
  endfunction

  // ==========================================================================
  // Decoder
  // ==========================================================================
  ppwm_decode u_decode (
    .addr_i(CPU_ADDR_I),
    .page_i(s_q.page),
    .base_i(s_q.base),
    .size_2k_i(REG_BLOCK_2K_I),
    .dec_o(dec_c)
  );

  // ==========================================================================
  // Bus helpers
  // ==========================================================================
  assign av_req = AVS_READ_I || AVS_WRITE_I;
  assign av_idx = {2'b00, AVS_ADDRESS_I[7:2]};
  assign av_aligned = (AVS_ADDRESS_I[1:0] == 2'b00);
  // A page write waits while a call or return owns the page register
  assign page_busy = AVS_WRITE_I && av_aligned && (av_idx == PPWM_IDX_PAGE_SEL) &&
                     (s_q.st != PPWM_IDLE); // [RULE12]

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    if (CE_I) begin
      s_d.done = 1'b0;
      s_d.dec = dec_c;
      // Bus: one wait cycle, answer on the second; unmapped reads give zero
      s_d.av_ack = av_req && !s_q.av_ack && !page_busy;
      if (av_req && !s_q.av_ack) begin
        s_d.rdata = 32'h0000_0000;
        if (av_aligned) begin
          case (av_idx)
            PPWM_IDX_BASE_POS: begin
              s_d.rdata = {24'h00_0000, s_q.base & PPWM_BASE_MASK};
            end
            PPWM_IDX_PAGE_SEL: begin
              s_d.rdata = {26'h000_0000, s_q.page};
            end
            PPWM_IDX_STATUS: begin
              s_d.rdata = {19'h0_0000, s_q.temp, s_q.locked, s_q.st, 1'b0, s_q.st != PPWM_IDLE};
            end
            default: begin
              s_d.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      // Writes take effect at the edge where waitrequest is low
      if (AVS_WRITE_I && s_q.av_ack && av_aligned) begin
        if (av_idx == PPWM_IDX_BASE_POS && (MODE_SPECIAL_I || !s_q.locked)) begin
          s_d.base = AVS_WRITEDATA_I[7:0] & PPWM_BASE_MASK; // [RULE1] [RULE3]
          s_d.locked = !MODE_SPECIAL_I; // [RULE1]
        end
        if (av_idx == PPWM_IDX_PAGE_SEL) begin
          s_d.page = AVS_WRITEDATA_I[5:0]; // [RULE4]
        end
      end
      // Sequencer
      case (s_q.st)
        PPWM_IDLE: begin
          // Any source and any target address are accepted
          if (CALL_REQ_I) begin // [RULE14]
            s_d.newpg = CMD_I.new_page; // [RULE13]
            s_d.ptr = CMD_I.target;
            s_d.tgt = CMD_I.target;
            s_d.ret = CMD_I.ret_addr; // [RULE9]
            s_d.sp = CMD_I.sp;
            s_d.st = CMD_I.indirect ? PPWM_IND_ADDR : PPWM_SWAP; // [RULE13]
          end else if (RTC_REQ_I) begin
            s_d.sp = CMD_I.sp;
            s_d.st = PPWM_POP_PAGE; // [RULE16]
          end
        end
        PPWM_IND_ADDR: begin
          if (MEM_ACK_I) begin
            s_d.tgt = MEM_RDATA_I; // [RULE13]
            s_d.st = PPWM_IND_PAGE;
          end
        end
        PPWM_IND_PAGE: begin
          if (MEM_ACK_I) begin
            s_d.newpg = MEM_RDATA_I[5:0]; // [RULE13]
            s_d.st = PPWM_SWAP;
          end
        end
        PPWM_SWAP: begin
          s_d.temp = s_q.page; // [RULE8]
          s_d.page = s_q.newpg; // [RULE8] [RULE4]
          s_d.st = PPWM_PUSH_RET;
        end
        PPWM_PUSH_RET: begin
          if (MEM_ACK_I) begin
            s_d.st = PPWM_PUSH_PAGE; // [RULE10]
          end
        end
        PPWM_PUSH_PAGE: begin
          if (MEM_ACK_I) begin
            s_d.sp = s_q.sp - PPWM_FRAME_BYTES;
            s_d.st = PPWM_REFILL;
          end
        end
        PPWM_POP_PAGE: begin
          if (MEM_ACK_I) begin
            s_d.page = MEM_RDATA_I[5:0]; // [RULE15] [RULE16]
            s_d.st = PPWM_POP_RET;
          end
        end
        PPWM_POP_RET: begin
          if (MEM_ACK_I) begin
            s_d.tgt = MEM_RDATA_I; // [RULE15] [RULE16]
            s_d.sp = s_q.sp + PPWM_FRAME_BYTES;
            s_d.st = PPWM_REFILL;
          end
        end
        PPWM_REFILL: begin
          // Queue refill restarts fetch in the page now selected
          s_d.done = 1'b1; // [RULE11] [RULE15]
          s_d.fetch.addr = s_q.tgt; // [RULE11]
          s_d.fetch.sp = s_q.sp;
          s_d.st = PPWM_IDLE;
        end
        default: begin
          s_d.st = PPWM_IDLE;
        end
      endcase
      // Memory request fields are registered with the state they belong to
      s_d.mem = mem_for(s_d.st, s_d.ptr, s_d.ret, s_d.sp, s_d.temp); // [RULE9] [RULE10]
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_q <= '0;
      s_q.base <= PPWM_BASE_POS_RST;
      s_q.page <= PPWM_PAGE_RST;
      s_q.st <= PPWM_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign AVS_READDATA_O = s_q.rdata;
  assign AVS_WAITREQUEST_O = av_req && !s_q.av_ack;
  assign DEC_O = s_q.dec;
  assign CMD_READY_O = (s_q.st == PPWM_IDLE);
  // The core holds off interrupts while this is high
  assign BUSY_O = (s_q.st != PPWM_IDLE); // [RULE12]
  assign MEM_REQ_O = is_mem_state(s_q.st);
  assign MEM_O = s_q.mem;
  assign DONE_O = s_q.done;
  assign FETCH_O = s_q.fetch;
  assign PAGE_O = s_q.page;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence seq_push_ret_done;
    CE_I && s_q.st == PPWM_PUSH_RET && MEM_ACK_I;
  endsequence

  sequence seq_push_page_done;
    CE_I && s_q.st == PPWM_PUSH_PAGE && MEM_ACK_I;
  endsequence

  a_base_once_lock: assert property ( // [RULE1]
    (CE_I && s_q.locked && !MODE_SPECIAL_I) |=> $stable(s_q.base))
    else $error("base position changed after lock");

  a_base_top_zero: assert property ( // [RULE3]
    s_q.base[7] == 1'b0 && s_q.base[2:0] == 3'b000)
    else $error("base position bit outside field set");

  a_reg_block_hit: assert property ( // [RULE2]
    (CE_I && CPU_ADDR_I[15]) |=> !DEC_O.reg_hit)
    else $error("register block decoded above 32K");

  a_unpaged_top: assert property ( // [RULE6]
    (CE_I && CPU_ADDR_I[15:14] == PPWM_UNPAGED_TOP) |=>
      (!DEC_O.win_hit && DEC_O.phys == {6'h00, $past(CPU_ADDR_I)}))
    else $error("top 16K decoded as paged");

  a_window_page: assert property ( // [RULE5]
    (CE_I && CPU_ADDR_I[15:14] == PPWM_WIN_TOP) |=>
      DEC_O.phys == {$past(s_q.page), $past(CPU_ADDR_I[13:0])})
    else $error("window address not on selected page");

  a_swap_page: assert property ( // [RULE8]
    (CE_I && s_q.st == PPWM_SWAP) |=>
      (s_q.page == $past(s_q.newpg) && s_q.temp == $past(s_q.page)))
    else $error("call page swap wrong");

  a_push_ret_word: assert property ( // [RULE9]
    (s_q.st == PPWM_PUSH_RET) |->
      (MEM_REQ_O && MEM_O.we && MEM_O.wide && MEM_O.wdata == s_q.ret &&
       MEM_O.addr == s_q.sp - PPWM_PUSH_RET_OFS))
    else $error("return address push wrong");

  a_push_page_next: assert property ( // [RULE10]
    seq_push_ret_done |=> (s_q.st == PPWM_PUSH_PAGE && MEM_O.we && !MEM_O.wide &&
                           MEM_O.wdata[5:0] == s_q.temp))
    else $error("page push does not follow return push");

  a_call_refill: assert property ( // [RULE11]
    seq_push_page_done ##1 CE_I |=> (DONE_O && FETCH_O.addr == $past(s_q.tgt, 2)))
    else $error("call does not refill at target");

  a_busy_atomic: assert property ( // [RULE12]
    (CE_I && s_q.st == PPWM_IDLE && CALL_REQ_I) |=> BUSY_O && !CMD_READY_O)
    else $error("call not marked uninterruptible");

  a_rtc_page_pop: assert property ( // [RULE16]
    (CE_I && s_q.st == PPWM_POP_PAGE && MEM_ACK_I) |=>
      (s_q.page == $past(MEM_RDATA_I[5:0]) && s_q.st == PPWM_POP_RET))
    else $error("return page pop wrong");

  a_rtc_resume: assert property ( // [RULE15]
    (CE_I && s_q.st == PPWM_POP_RET && MEM_ACK_I) ##1 CE_I |=>
      (DONE_O && FETCH_O.addr == $past(MEM_RDATA_I, 2)))
    else $error("return does not resume at popped address");
endmodule

// *** sim/ppwm_core_model.sv ***
// Behavioural model of the core's stack and operand memory behind the sequencer port
`timescale 1ns/1ps
module ppwm_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire ppwm_pkg::ppwm_mem_t mem_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  import ppwm_pkg::*;
  // ==========================================================================
  // Storage and access log
  // ==========================================================================
  logic [7:0] mem [0:65535]; // Byte memory, word accesses are big-endian
  logic [17:0] log [$]; // One entry per access: write, wide, address
  logic [1:0] wait_q; // Wait cycles spent on the pending access

  // Answers after two wait cycles when slow, so the sequencer must hold its request
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'b00;
      rdata_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      // Read data is only valid with the acknowledge; scramble it otherwise
      rdata_o <= ~rdata_o;
      if (mem_req_i && !ack_o) begin
        if (slow_i && wait_q != 2'b10) begin
          wait_q <= wait_q + 2'b01;
        end else begin
          wait_q <= 2'b00;
          ack_o <= 1'b1;
          log.push_back({mem_i.we, mem_i.wide, mem_i.addr});
          if (mem_i.we && mem_i.wide) begin
            mem[mem_i.addr] <= mem_i.wdata[15:8];
            mem[mem_i.addr + 16'h0001] <= mem_i.wdata[7:0];
          end else if (mem_i.we) begin
            mem[mem_i.addr] <= mem_i.wdata[7:0];
          end else if (mem_i.wide) begin
            rdata_o <= {mem[mem_i.addr], mem[mem_i.addr + 16'h0001]};
          end else begin
            rdata_o <= {8'h00, mem[mem_i.addr]};
          end
        end
      end
    end
  end
endmodule

// *** sim/ppwm_tb_top.sv ***
// Self-checking testbench of the program page window mapper
`timescale 1ns/1ps
module ppwm_tb_top;
  import ppwm_pkg::*;
  // ==========================================================================
  // Stimulus signals
  // ==========================================================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic special = 1'b0; // Special mode lifts the write-once lock
  logic blk2k = 1'b0; // Register block size
  logic [7:0] av_addr = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0000_0000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [15:0] cpu_addr = 16'h0000;
  ppwm_dec_t dec;
  logic call_req = 1'b0;
  logic rtc_req = 1'b0;
  ppwm_cmd_t cmd = '0;
  logic cmd_ready, busy, mem_req, mem_ack, done;
  ppwm_mem_t mem_bus;
  logic [15:0] mem_rdata;
  ppwm_fetch_t fetch;
  logic [5:0] page;
  logic slow = 1'b0;
  logic ce = 1'b1; // Clock enable of the design
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] r;

  always #2 clk = ~clk;

  ppwm_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .MODE_SPECIAL_I(special),
    .REG_BLOCK_2K_I(blk2k), .AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
    .AVS_WRITEDATA_I(av_wd), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
    .CPU_ADDR_I(cpu_addr), .DEC_O(dec), .CALL_REQ_I(call_req), .RTC_REQ_I(rtc_req), .CMD_I(cmd),
    .CMD_READY_O(cmd_ready), .BUSY_O(busy), .MEM_REQ_O(mem_req), .MEM_O(mem_bus),
    .MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata), .DONE_O(done), .FETCH_O(fetch), .PAGE_O(page));

  ppwm_core_model mem_model (.clk_i(clk), .rst_i(rst), .slow_i(slow), .mem_req_i(mem_req),
    .mem_i(mem_bus), .ack_o(mem_ack), .rdata_o(mem_rdata));

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("ERROR %0t timeout", $time);
      wrap_up();
    end
  end

  // ==========================================================================
  // Bus and sequencer tasks
  // ==========================================================================
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    do @(posedge clk); while (av_wait !== 1'b0);
    r = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string msg);
    avs(1'b0, a, 32'h0000_0000);
    chk(r === e, msg);
  endtask

  // Decoder output is registered one cycle behind the address
  task automatic dec_chk(input logic [15:0] a, input logic rh, input logic wh, input logic [21:0] ph);
    @(posedge clk);
    cpu_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(dec.reg_hit === rh && dec.win_hit === wh && dec.phys === ph, "decode mismatch");
  endtask

  // One call or return, checking the sequencer stays busy until its done pulse
  task automatic run(input logic is_call, input ppwm_cmd_t c);
    int n;
    n = 0;
    mem_model.log.delete();
    @(posedge clk);
    cmd <= c;
    call_req <= is_call;
    rtc_req <= !is_call;
    @(posedge clk);
    call_req <= 1'b0;
    rtc_req <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (done !== 1'b1) chk(busy === 1'b1 && cmd_ready === 1'b0, "idle mid sequence");
    end while (done !== 1'b1 && n < 100);
    chk(done === 1'b1, "sequence did not finish");
  endtask

  function automatic bit log_is(input int i, input logic [17:0] e);
    return mem_model.log.size() > i && mem_model.log[i] === e;
  endfunction

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h44, 32'h0000_0000, "base reset value");
    rd_chk(8'h48, 32'h0000_0000, "page reset value");
    // Write-once base position; bit 7 and low bits read zero
    avs(1'b1, 8'h44, 32'h0000_00FF);
    rd_chk(8'h44, 32'h0000_0078, "base field mask");
    avs(1'b1, 8'h44, 32'h0000_0008);
    rd_chk(8'h44, 32'h0000_0078, "second write not locked out");
    dec_chk(16'h7804, 1'b1, 1'b0, {6'h00, 16'h7804});
    dec_chk(16'h7C04, 1'b0, 1'b0, {6'h00, 16'h7C04});
    @(posedge clk);
    blk2k <= 1'b1;
    dec_chk(16'h7C04, 1'b1, 1'b0, {6'h00, 16'h7C04});
    dec_chk(16'h8004, 1'b0, 1'b1, {8'h00, 14'h0004});
    @(posedge clk);
    special <= 1'b1;
    avs(1'b1, 8'h44, 32'h0000_0000);
    rd_chk(8'h44, 32'h0000_0000, "special mode rewrite lost");
    dec_chk(16'h0000, 1'b1, 1'b0, {6'h00, 16'h0000});
    avs(1'b1, 8'h44, 32'h0000_0010);
    rd_chk(8'h44, 32'h0000_0010, "special mode rewrite lost");
    dec_chk(16'h1000, 1'b1, 1'b0, {6'h00, 16'h1000});
    dec_chk(16'h0FFF, 1'b0, 1'b0, {6'h00, 16'h0FFF});
    // Clock enable low freezes the registered decode
    @(posedge clk);
    ce <= 1'b0;
    cpu_addr <= 16'hC000;
    repeat (3) @(posedge clk);
    chk(dec.phys === {6'h00, 16'h0FFF}, "state moved with enable low");
    ce <= 1'b1;
    // Page select at both ends of its range and in between; 0x25 is left set
    for (int i = 0; i < 3; i++) begin
      logic [5:0] p;
      p = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'h25;
      avs(1'b1, 8'h48, {26'h000_0000, p});
      rd_chk(8'h48, {26'h000_0000, p}, "page readback");
      chk(page === p, "page output");
      dec_chk(16'h8123, 1'b0, 1'b1, {2'b00, p, 14'h0123});
      dec_chk(16'hBFFF, 1'b0, 1'b1, {2'b00, p, 14'h3FFF});
      dec_chk(16'hC123, 1'b0, 1'b0, {6'h00, 16'hC123});
    end
    // Unmapped places read zero and swallow writes
    avs(1'b1, 8'h80, 32'h0000_00FF);
    rd_chk(8'h80, 32'h0000_0000, "unmapped read");
    rd_chk(8'h49, 32'h0000_0000, "misaligned read");
    rd_chk(8'h48, 32'h0000_0025, "page disturbed");
    // Direct call from page 0x25 to page 0x2A, slow memory; return point kept unpaged
    slow <= 1'b1;
    run(1'b1, '{1'b0, 6'h2A, 16'h8800, 16'hC010, 16'h3F00});
    chk(page === 6'h2A, "new page not loaded");
    chk(log_is(0, {2'b11, 16'h3EFE}) && log_is(1, {2'b10, 16'h3EFD}), "push order");
    chk(mem_model.mem[16'h3EFE] === 8'hC0 && mem_model.mem[16'h3EFF] === 8'h10, "return word");
    chk(mem_model.mem[16'h3EFD][5:0] === 6'h25, "saved page");
    chk(fetch.addr === 16'h8800 && fetch.sp === 16'h3EFD, "call fetch");
    // Return with prompt memory
    slow <= 1'b0;
    run(1'b0, '{1'b0, 6'h00, 16'h0000, 16'h0000, 16'h3EFD});
    chk(log_is(0, {2'b00, 16'h3EFD}) && log_is(1, {2'b01, 16'h3EFE}), "pop order");
    chk(page === 6'h25 && fetch.addr === 16'hC010 && fetch.sp === 16'h3F00, "return");
    // Indirect call: target word and page byte come through the pointer
    mem_model.mem[16'h2000] = 8'h91;
    mem_model.mem[16'h2001] = 8'h00;
    mem_model.mem[16'h2002] = 8'h07;
    run(1'b1, '{1'b1, 6'h3F, 16'h2000, 16'h4000, 16'h3F00});
    chk(log_is(0, {2'b01, 16'h2000}) && log_is(1, {2'b00, 16'h2002}), "pointer reads");
    chk(page === 6'h07 && fetch.addr === 16'h9100, "indirect target");
    rd_chk(8'h48, 32'h0000_0007, "page after call");
    rd_chk(8'h4C, 32'h0000_1280, "status old page");
    wrap_up();
  end
endmodule
